// ===== core/lsp_defs.svh
// Constants for the LED sink shift and latch port
`ifndef LSP_DEFS_SVH
`define LSP_DEFS_SVH

// ----------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------
`define LSP_CHANNELS      16
`define LSP_LOG_DEPTH     16
`define LSP_LOG_PTR_W     4
// Serial output tap: captured bit leaves 8.5 serial clocks later
`define LSP_OUT_TAP       8

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define LSP_ADDR_W        6
`define LSP_OFF_CTRL      6'h00
`define LSP_OFF_STATUS    6'h04
`define LSP_OFF_DISPLAY   6'h08
`define LSP_OFF_SHIFT     6'h0c
`define LSP_OFF_TEMP      6'h10
`define LSP_OFF_OPEN      6'h14
`define LSP_OFF_SHORT     6'h18
`define LSP_OFF_LOG       6'h1c
`define LSP_OFF_LOGSTAT   6'h20

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LSP_CTRL_ERRMODE  0
`define LSP_CTRL_LOWCUR   1
`define LSP_CTRL_LOGEN    2
`define LSP_CTRL_W        3
`define LSP_STAT_FAULT    0
`define LSP_STAT_MODE_LSB 4
`define LSP_STAT_PEND     8
`define LSP_LOG_VALID     16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LSP_CTRL_RST      3'h0

// ----------------------------------------------------------------------
// AHB-Lite codes
// ----------------------------------------------------------------------
`define LSP_HTRANS_NONSEQ 2'h2
`define LSP_HRESP_OKAY    1'h0

`endif

// ===== core/lsp_pkg.sv
// Types for the LED sink shift and latch port
package lsp_pkg;

  // Serial port operating modes
  typedef enum logic [2:0] {
    LSP_NORMAL,
    LSP_GLOBAL,
    LSP_TEMP,
    LSP_OPEN,
    LSP_SHORT
  } lsp_mode_type;

endpackage

// ===== core/lsp_fifo.sv
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/1ns
`include "lsp_defs.svh"

module lsp_fifo #(
  parameter int WIDTH = `LSP_CHANNELS,
  parameter int DEPTH = `LSP_LOG_DEPTH,
  parameter int PTRW  = `LSP_LOG_PTR_W
) (
  input  wire logic             core_clk,  // Core clock
  input  wire logic             rst_n,     // Asynchronous reset, active low
  input  wire logic             inValid,   // Write side offers a word
  output logic                  inReady,   // Room for a word
  input  wire logic [WIDTH-1:0] inData,    // Word to store
  output logic                  outValid,  // A word is held
  input  wire logic             outReady,  // Read side takes the word
  output logic      [WIDTH-1:0] outData,   // Oldest word
  output logic      [PTRW:0]    level      // Words held
);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PTRW-1:0]  wrPtr;
  logic [PTRW-1:0]  rdPtr;
  logic [PTRW:0]    count;
  wire              doPush;
  wire              doPop;

  assign inReady  = (count != (PTRW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;
  assign outData  = store[rdPtr];
  assign level    = count;

  always_ff @(posedge core_clk) begin
    if (doPush) begin
      store[wrPtr] <= inData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == PTRW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == PTRW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (PTRW+1)'(doPush) - (PTRW+1)'(doPop);
    end
  end

endmodule // lsp_fifo

// ===== core/lsp_shift_latch.sv
// Serial shift register, display latch, diagnostics and AHB-Lite register file
//
// Implementation choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`include "lsp_defs.svh"

// What this block does
// - In normal mode each serial clock rise shifts serial_in in and moves held bits onward
// - In an error mode each serial clock rise steps to the next mode
// - Sixteen sink channels, each driven by one latched pattern bit
// - Displayed pattern sits in its own latch, untouched by shifting
// - Low drive_enable_n lets channels sink; high disables all, in any mode
// - Normal mode: each bit leaves serial_out 8.5 serial clocks after capture
// - Global error mode: serial_out low means fault, high means none
// - Diagnostics derive fault results from channel pin sensing
// - Global fault kept at load; per-channel temp, open, short results kept
// - Low-current diagnostic mode reduces channel current while testing
module lsp_shift_latch #(
  parameter int CHANNELS = `LSP_CHANNELS,
  parameter int OUT_TAP  = `LSP_OUT_TAP
) (
  input  wire logic                core_clk,       // Core clock, 100 MHz
  input  wire logic                rst_n,          // Asynchronous reset, active low
  // Serial pins
  input  wire logic                serialClk,      // Serial shift clock
  input  wire logic                serial_in,      // Serial data in
  input  wire logic                load_strobe,    // Latch strobe
  input  wire logic                drive_enable_n, // Channel enable, active low
  output logic                     serial_out,     // Serial data or fault out
  output logic [CHANNELS-1:0]      sink_channels,  // Channel sink on
  output logic                     lowCurrent,     // Reduced current request
  // Channel pin sense
  input  wire logic [CHANNELS-1:0] senseOpen,      // Channel open-LED sense
  input  wire logic [CHANNELS-1:0] senseShort,     // Channel shorted-LED sense
  input  wire logic [CHANNELS-1:0] senseHot,       // Channel over-temperature sense
  // AHB-Lite slave
  input  wire logic                hsel,           // Slave select
  input  wire logic [31:0]         haddr,          // Address
  input  wire logic [1:0]          htrans,         // Transfer type
  input  wire logic                hwrite,         // Write not read
  input  wire logic [2:0]          hsize,          // Transfer size
  input  wire logic [31:0]         hwdata,         // Write data
  input  wire logic                hready,         // Bus ready
  output logic [31:0]              hrdata,         // Read data
  output logic                     hreadyout,      // Slave ready
  output logic                     hresp           // Response
);
  import lsp_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  lsp_mode_type            mode;
  lsp_mode_type            next_mode;
  logic [CHANNELS-1:0]     shiftReg;
  logic [CHANNELS-1:0]     displayReg;
  logic [CHANNELS-1:0]     tempResult;
  logic [CHANNELS-1:0]     openResult;
  logic [CHANNELS-1:0]     shortResult;
  logic                    globalFault;
  logic                    loadPending;
  logic                    clkPrev;
  logic                    loadPrev;
  logic [`LSP_CTRL_W-1:0]  ctrl;
  logic                    wrPhase;
  logic [`LSP_ADDR_W-1:0]  wrAddr;
  logic [`LSP_LOG_PTR_W:0] logLevel;
  logic                    logValid;
  logic                    logReady;
  logic [CHANNELS-1:0]     logData;
  logic [31:0]             statusWord;
  logic [31:0]             logWord;

  // ----------------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------------
  wire errModeOn = ctrl[`LSP_CTRL_ERRMODE];
  wire lowCurOn  = ctrl[`LSP_CTRL_LOWCUR];
  wire logOn     = ctrl[`LSP_CTRL_LOGEN];

  // ----------------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------------
  // Previous samples reset to the idle low level, so no false edge follows reset
  wire clkRise  = serialClk && !clkPrev;
  wire clkFall  = !serialClk && clkPrev;
  wire loadRise = load_strobe && !loadPrev;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev  <= 1'b0;
      loadPrev <= 1'b0;
    end else begin
      clkPrev  <= serialClk;
      loadPrev <= load_strobe;
    end
  end

  // ----------------------------------------------------------------------
  // Load path and fault capture
  // ----------------------------------------------------------------------
  wire errorMode  = (mode != LSP_NORMAL);
  wire loadWanted = loadRise || loadPending;
  // A load waits while logging is on and the pattern log is full; a rise meanwhile merges into it
  wire loadDo     = loadWanted && (!logOn || logReady);
  wire [CHANNELS-1:0] openNow;
  wire [CHANNELS-1:0] shortNow;
  wire                faultNow = (|openNow) || (|shortNow) || (|senseHot);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loadPending <= 1'b0;
    end else begin
      loadPending <= loadWanted && !loadDo;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      displayReg <= '0;
    end else if (loadDo) begin
      displayReg <= shiftReg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      globalFault <= 1'b0;
      tempResult  <= '0;
      openResult  <= '0;
      shortResult <= '0;
    end else if (loadDo) begin
      // Results stay put until the next load so software can read them back
      globalFault <= faultNow;
      tempResult  <= senseHot;
      openResult  <= openNow;
      shortResult <= shortNow;
    end
  end

  // ----------------------------------------------------------------------
  // Mode sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    next_mode = mode;
    // Only a load with the error mode bit set starts a report sequence
    if (loadDo && errModeOn && !errorMode) begin
      next_mode = LSP_GLOBAL;
    end else if (clkRise) begin
      unique case (mode)
        LSP_NORMAL: next_mode = LSP_NORMAL;
        LSP_GLOBAL: next_mode = LSP_TEMP;
        LSP_TEMP:   next_mode = LSP_OPEN;
        LSP_OPEN:   next_mode = LSP_SHORT;
        LSP_SHORT:  next_mode = LSP_NORMAL;
        default:    next_mode = LSP_NORMAL;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= LSP_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg <= '0;
    end else if (clkRise && !errorMode) begin
      // Error modes freeze the pattern; the clock then only steps the report
      shiftReg <= {shiftReg[CHANNELS-2:0], serial_in};
    end
  end

  // ----------------------------------------------------------------------
  // Serial output
  // ----------------------------------------------------------------------
  logic next_serialOut;
  // Report modes pull serial_out low when any channel of that result is flagged
  wire  tempFlag  = |tempResult;
  wire  openFlag  = |openResult;
  wire  shortFlag = |shortResult;

  always_comb begin
    next_serialOut = serial_out;
    unique case (mode)
      LSP_NORMAL: if (clkFall) next_serialOut = shiftReg[OUT_TAP];
      LSP_GLOBAL: next_serialOut = !globalFault;
      LSP_TEMP:   next_serialOut = !tempFlag;
      LSP_OPEN:   next_serialOut = !openFlag;
      LSP_SHORT:  next_serialOut = !shortFlag;
      default:    next_serialOut = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= next_serialOut;
    end
  end

  // ----------------------------------------------------------------------
  // Channel drivers
  // ----------------------------------------------------------------------
  wire [CHANNELS-1:0] next_sink;

  // Sense taps share the per-channel loop with the drivers
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : gChan
      assign next_sink[ch] = displayReg[ch] && !drive_enable_n;
      assign openNow[ch]   = senseOpen[ch] && shiftReg[ch];
      assign shortNow[ch]  = senseShort[ch] && shiftReg[ch];
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sink_channels <= '0;
      lowCurrent    <= 1'b0;
    end else begin
      sink_channels <= next_sink;
      lowCurrent    <= lowCurOn && errorMode;
    end
  end

  // ----------------------------------------------------------------------
  // Pattern log FIFO
  // ----------------------------------------------------------------------
  wire logPop;

  lsp_fifo #(
    .WIDTH (CHANNELS),
    .DEPTH (`LSP_LOG_DEPTH),
    .PTRW  (`LSP_LOG_PTR_W)
  ) uLog (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .inValid  (loadDo && logOn),
    .inReady  (logReady),
    .inData   (shiftReg),
    .outValid (logValid),
    .outReady (logPop),
    .outData  (logData),
    .level    (logLevel)
  );

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  wire                   addrPhase = hsel && hready && (htrans == `LSP_HTRANS_NONSEQ);
  wire                   rdTake    = addrPhase && !hwrite;
  wire [`LSP_ADDR_W-1:0] rdAddr    = haddr[`LSP_ADDR_W-1:0];
  wire                   addrHigh  = |haddr[31:`LSP_ADDR_W];
  assign logPop = rdTake && !addrHigh && (rdAddr == `LSP_OFF_LOG);

  // ----------------------------------------------------------------------
  // Status and log words
  // ----------------------------------------------------------------------
  // Fields placed by their positions; all other bits read as zero
  always_comb begin
    statusWord                          = 32'h0;
    statusWord[`LSP_STAT_FAULT]         = globalFault;
    statusWord[`LSP_STAT_MODE_LSB +: 3] = mode;
    statusWord[`LSP_STAT_PEND]          = loadPending;
  end

  // An empty log reads as zero rather than a stale slot
  always_comb begin
    logWord                 = 32'h0;
    logWord[CHANNELS-1:0]   = logValid ? logData : '0;
    logWord[`LSP_LOG_VALID] = logValid;
  end

  wire [31:0] logStat    = {27'h0, logLevel};

  // ----------------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------------
  logic [31:0] readMux;

  always_comb begin
    readMux = 32'h0;
    if (!addrHigh) begin
      unique case (rdAddr)
        `LSP_OFF_CTRL:    readMux = {29'h0, ctrl};
        `LSP_OFF_STATUS:  readMux = statusWord;
        `LSP_OFF_DISPLAY: readMux = {16'h0, displayReg};
        `LSP_OFF_SHIFT:   readMux = {16'h0, shiftReg};
        `LSP_OFF_TEMP:    readMux = {16'h0, tempResult};
        `LSP_OFF_OPEN:    readMux = {16'h0, openResult};
        `LSP_OFF_SHORT:   readMux = {16'h0, shortResult};
        `LSP_OFF_LOG:     readMux = logWord;
        `LSP_OFF_LOGSTAT: readMux = logStat;
        default:          readMux = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus phase tracking and register write
  // ----------------------------------------------------------------------
  wire ctrlWrite = wrPhase && (wrAddr == `LSP_OFF_CTRL);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPhase   <= 1'b0;
      wrAddr    <= '0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= `LSP_HRESP_OKAY;
    end else begin
      if (hready) begin
        wrPhase <= addrPhase && hwrite && !addrHigh;
        wrAddr  <= rdAddr;
      end
      if (rdTake) begin
        hrdata <= readMux;
      end
      // Zero wait states and always OKAY: every transfer ends in one data phase
      hreadyout <= 1'b1;
      hresp     <= `LSP_HRESP_OKAY;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `LSP_CTRL_RST;
    end else if (ctrlWrite) begin
      ctrl <= hwdata[`LSP_CTRL_W-1:0];
    end
  end

endmodule // lsp_shift_latch

// ===== verification/lsp_ctl_model.sv
// Display controller model driving the serial pins
`timescale 1ns/1ns
module lsp_ctl_model (
  input  wire logic core_clk,       // Core clock
  output logic      serialClk,      // Shift clock
  output logic      serial_in,      // Serial data
  output logic      load_strobe,    // Latch strobe
  output logic      drive_enable_n  // Channel enable
);
  initial begin
    serialClk = 1'b0;
    serial_in = 1'b0;
    load_strobe = 1'b0;
    drive_enable_n = 1'b0;
  end
  // Each clock level held two core clocks or more; data turned round with the fall
  task automatic pulse(input logic b);
    @(posedge core_clk);
    serial_in <= b;
    serialClk <= 1'b1;
    repeat (2) @(posedge core_clk);
    serialClk <= 1'b0;
    serial_in <= ~b;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic load();
    @(posedge core_clk);
    load_strobe <= 1'b1;
    repeat (2) @(posedge core_clk);
    load_strobe <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic enable(input logic v);
    @(posedge core_clk);
    drive_enable_n <= v;
  endtask
endmodule // lsp_ctl_model

// ===== verification/lsp_shift_latch_sva.sv
// Checker for the LED sink shift and latch port
`timescale 1ns/1ns
module lsp_shift_latch_sva #(
  parameter int CHANNELS = 16
) (
  input wire logic                core_clk,       // Clock
  input wire logic                rst_n,          // Reset
  input wire logic                serialClk,      // Shift clock
  input wire logic                load_strobe,    // Latch strobe
  input wire logic                drive_enable_n, // Channel enable
  input wire logic                serial_out,     // Serial out
  input wire logic [CHANNELS-1:0] sink_channels,  // Channels
  input wire logic                lowCurrent,     // Low current
  input wire logic                hsel,           // Select
  input wire logic [31:0]         haddr,          // Address
  input wire logic [1:0]          htrans,         // Transfer type
  input wire logic                hwrite,         // Write
  input wire logic                hready,         // Bus ready
  input wire logic [31:0]         hrdata,         // Read data
  input wire logic                hreadyout,      // Slave ready
  input wire logic                hresp           // Response
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire rdReq = hsel && hready && htrans == 2'h2 && !hwrite;
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_chan_gate: assert property ($past(drive_enable_n) |-> sink_channels == '0)
    else $error("channels on while disabled");
  a_chan_hold: assert property ($changed(sink_channels) && !$past(drive_enable_n) && !$past(drive_enable_n, 2)
    |-> $past(load_strobe) || $past(hsel, 2) || $past(hsel, 3)) else $error("channels moved without load");
  a_read_unmapped: assert property (rdReq && haddr > 32'h20 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!rdReq |=> $stable(hrdata)) else $error("read data moved");
  a_lowcur_rise: assert property ($rose(lowCurrent) |-> $past(load_strobe) || $past(htrans, 3) == 2'h2)
    else $error("low current without cause");
  a_sdo_steady: assert property (serialClk && $past(serialClk) && $past(serialClk, 2) && !$past(load_strobe)
    && !$past(load_strobe, 2) |-> $stable(serial_out)) else $error("serial out moved while clock high");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |-> !serial_out && sink_channels == '0 && !lowCurrent)
    else $error("outputs active in reset");
  c_load: cover property ($rose(load_strobe));
  c_lowcur: cover property ($rose(lowCurrent));
  c_gate: cover property ($fell(drive_enable_n) ##2 sink_channels != '0);
endmodule // lsp_shift_latch_sva

bind lsp_shift_latch lsp_shift_latch_sva #(.CHANNELS(CHANNELS)) i_sva (.core_clk, .rst_n, .serialClk, .load_strobe,
  .drive_enable_n, .serial_out, .sink_channels, .lowCurrent, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata,
  .hreadyout, .hresp);

// ===== verification/tb.sv
// Testbench for the LED sink shift and latch port
`timescale 1ns/1ns
`include "lsp_defs.svh"
module tb;
  import lsp_pkg::*;
  logic         core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic         serialClk, serial_in, load_strobe, drive_enable_n, serial_out, lowCurrent, f;
  logic [31:0]  haddr, hwdata, hrdata, rd, rng;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [15:0]  sink_channels, senseOpen, senseShort, senseHot, word, shown, hot, opn, sht;
  logic [3:0]   rep;
  logic         hist[$];
  lsp_mode_type stp[4] = '{LSP_TEMP, LSP_OPEN, LSP_SHORT, LSP_NORMAL};
  int           errors, n_tests;
  lsp_shift_latch i_dut (.core_clk, .rst_n, .serialClk, .serial_in, .load_strobe, .drive_enable_n, .serial_out,
    .sink_channels, .lowCurrent, .senseOpen, .senseShort, .senseHot, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
  lsp_ctl_model i_ctl (.core_clk, .serialClk, .serial_in, .load_strobe, .drive_enable_n);
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic fault_of(input logic [15:0] w, h, o, s);
    return |h || |(o & w) || |(s & w);
  endfunction
  task automatic tally_and_finish();
    $display("errors %0d of %0d checks", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wt();
    int k;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (k >= 50) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic ahb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= `LSP_HTRANS_NONSEQ;
    haddr <= {26'h0, a};
    hwrite <= w;
    wt();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
  endtask
  task automatic send(input logic [15:0] w, input logic nrm);
    for (int i = 15; i >= 0; i--) begin
      i_ctl.pulse(w[i]);
      if (nrm) begin
        hist.push_back(w[i]);
        if (hist.size() > 8) chk("serial_out", 32'(serial_out), 32'(hist[hist.size()-9]));
      end
    end
  endtask
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, errors, n_tests, shown} = '0;
    {senseOpen, senseShort, senseHot} = '0;
    hsize = 3'h2;
    rst_n = 1'b1;
    #1 rst_n = 1'b0;
    rng = 32'd72;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    ahb(1'b0, `LSP_OFF_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    ahb(1'b1, `LSP_OFF_CTRL, 32'hffffffff);
    ahb(1'b0, `LSP_OFF_CTRL, 32'h0);
    chk("ctrl", rd, 32'h7);
    ahb(1'b1, `LSP_OFF_CTRL, 32'h0);
    ahb(1'b0, 6'h24, 32'h0);
    chk("unmapped", rd, 32'h0);
    for (int j = 0; j < 4; j++) begin
      rng = xs(rng);
      word = (j == 3) ? 16'h0001 : rng[15:0];
      rng = xs(rng);
      hot = (j == 3) ? 16'h0 : rng[15:0] & rng[31:16];
      opn = (j == 3) ? ~word : rng[31:16];
      sht = (j == 3) ? 16'h0 : rng[15:0];
      senseHot <= hot;
      senseOpen <= opn;
      senseShort <= sht;
      f = fault_of(word, hot, opn, sht);
      rep = {word[`LSP_OUT_TAP], !(|(sht & word)), !(|(opn & word)), !(|hot)};
      send(word, 1'b1);
      chk("sink held", 32'(sink_channels), 32'(shown));
      ahb(1'b0, `LSP_OFF_SHIFT, 32'h0);
      chk("shift", rd, 32'(word));
      if (j >= 2) ahb(1'b1, `LSP_OFF_CTRL, 32'h3);
      i_ctl.load();
      ahb(1'b0, `LSP_OFF_DISPLAY, 32'h0);
      chk("display", rd, 32'(word));
      if (j == 1) begin
        i_ctl.enable(1'b1);
        repeat (3) @(posedge core_clk);
        chk("sink off", 32'(sink_channels), 32'h0);
        i_ctl.enable(1'b0);
        repeat (3) @(posedge core_clk);
      end
      chk("sink", 32'(sink_channels), 32'(word));
      shown = word;
      if (j >= 2) begin
        ahb(1'b0, `LSP_OFF_STATUS, 32'h0);
        chk("status", rd, 32'(f) | (32'(LSP_GLOBAL) << 4));
        chk("fault out", 32'(serial_out), 32'(!f));
        chk("low cur", 32'(lowCurrent), 32'h1);
        ahb(1'b0, `LSP_OFF_TEMP, 32'h0);
        chk("temp", rd, 32'(hot));
        ahb(1'b0, `LSP_OFF_OPEN, 32'h0);
        chk("open", rd, 32'(opn & word));
        ahb(1'b0, `LSP_OFF_SHORT, 32'h0);
        chk("short", rd, 32'(sht & word));
        for (int k = 0; k < 4; k++) begin
          i_ctl.pulse(rng[k]);
          ahb(1'b0, `LSP_OFF_STATUS, 32'h0);
          chk("mode", 32'(rd[6:4]), 32'(stp[k]));
          chk("report out", 32'(serial_out), 32'(rep[k]));
        end
        chk("low cur off", 32'(lowCurrent), 32'h0);
        ahb(1'b1, `LSP_OFF_CTRL, 32'h0);
      end
    end
    ahb(1'b1, `LSP_OFF_CTRL, 32'h4);
    i_ctl.load();
    ahb(1'b0, `LSP_OFF_LOGSTAT, 32'h0);
    chk("log level", rd, 32'h1);
    ahb(1'b0, `LSP_OFF_LOG, 32'h0);
    chk("log word", rd, 32'h10000 | 32'(word));
    ahb(1'b0, `LSP_OFF_LOGSTAT, 32'h0);
    chk("log empty", rd, 32'h0);
    tally_and_finish();
  end
endmodule // tb
